/* rtl/edge_check_pkg.sv */
// Purpose: Shared constants, register map and carrier types of the edge timing bit check block.
// Assumes: 50 MHz system clock; registers sit on a classic Wishbone bus with 32-bit data.
// Notes:   Offsets are byte addresses; each register takes one aligned word.
package edge_check_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam logic [7:0] CONFIG_OFS  = 8'h00;
    localparam logic [7:0] LIMIT_OFS   = 8'h04;
    localparam logic [7:0] CONTROL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS  = 8'h0c;

    // Control register write-one command bits.
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_POLL_BIT  = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier types.
    typedef struct packed {
        logic       noise_squelch;
        logic [1:0] bit_code;
        logic [1:0] baud_range_select;
    } cfg_t;

    typedef struct packed {
        logic [4:0] lim_max;
        logic [4:0] lim_min;
    } limit_t;

    typedef enum logic [1:0] {
        ST_SLEEP   = 2'b00,
        ST_STARTUP = 2'b01,
        ST_CHECK   = 2'b11,
        ST_RECEIVE = 2'b10
    } mode_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values: squelch on, three bits, slowest range, limits 14 and 24.
    localparam logic [4:0] CFG_RESET   = 5'h14;
    localparam logic [9:0] LIMIT_RESET = 10'h30e;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int         SYS_CLK_NS       = 20;
    localparam int         T_CLK_NS         = 2038;
    localparam int         BASE_DIV_CYCLES  = T_CLK_NS / SYS_CLK_NS;
    localparam logic [5:0] STARTUP_TICKS    = 6'h10;
    localparam logic [4:0] CHECKS_PER_STEP  = 5'h06;
    localparam logic [5:0] DATA_MIN_TICKS   = 6'h04;
    localparam logic [7:0] DATA_LOW_MAX     = 8'h80;
    localparam logic [5:0] CNT_SAT          = 6'h3f;

endpackage

/* rtl/edge_timing_bit_check.sv */
// Purpose: Bit check and receive path of a receiver data line, with a Wishbone register slave.
// Assumes: DEM_DATA_IN is asynchronous to SYS_CLK_IN; the host writes sane limits.
// Notes:   All timing runs on the extended tick derived from the base clock and the baud range.
`timescale 1ns/1ps

// Operation
// [R1] Check 0, 3, 6 or 9 bits, two intervals each.
// [R2] Interval inside limits continues, otherwise back to sleep.
// [R3] Lower limit min ticks, upper max minus one.
// [R4] Two 5-bit limit fields in limit register.
// [R5] Limits resolve in whole extended ticks only.
// [R6] Host keeps lower limit at least 10.
// [R7] Host picks 6 or 9 bits for small limits.
// [R8] Host sets window about 25 percent around spacing.
// [R9] Interval counter advances once per extended tick.
// [R10] Early edge fails; counter reaching upper limit fails.
// [R11] Demodulator ignored during startup, checking begins afterwards.
// [R12] All bits passed enters receiving, data drives output.
// [R13] Receiving holds until host commands return to polling.
// [R14] Output changes only on extended tick boundaries; the code also forces it high the cycle after leaving receiving, off the tick.
// [R15] Minimum spacing between output edges suppresses spikes.
// [R16] Output low time capped at a maximum.
// [R17] After transmission stay active; squelch high or noise.
// [R18] Host wakes on falling data edge or clock.
// [R19] Tick is 8, 4, 2, 1 base periods.
// [R20] Squelch returns to checking with output high, resumes.
// [R21] Interval counter clears on every accepted edge.
// [R22] Zero bits enters receiving straight after startup.
module edge_timing_bit_check
    import edge_check_pkg::*;
#(
    parameter int BASE_DIV = edge_check_pkg::BASE_DIV_CYCLES
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    input  wire logic        DEM_DATA_IN,
    output logic             DATA_OUT,
    output logic             ACTIVE_OUT,
    output logic             RECEIVE_OUT
);
    import edge_check_pkg::*;

    function automatic logic [3:0] tick_len(input logic [1:0] br);
        case (br)
            2'd0:    tick_len = 4'h8;
            2'd1:    tick_len = 4'h4;
            2'd2:    tick_len = 4'h2;
            default: tick_len = 4'h1;
        endcase
    endfunction

    function automatic logic [4:0] checks_needed(input logic [1:0] code);
        case (code)
            2'd0:    checks_needed = 5'h00;
            2'd1:    checks_needed = CHECKS_PER_STEP;
            2'd2:    checks_needed = 5'(CHECKS_PER_STEP * 2);
            default: checks_needed = 5'(CHECKS_PER_STEP * 3);
        endcase
    endfunction

    localparam logic [15:0] BASE_LAST = 16'(BASE_DIV - 1);

    cfg_t        cfg_q;
    limit_t      lim_q;
    mode_t       state_q;
    mode_t       state_d;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [15:0] base_cnt_q;
    logic [3:0]  ext_cnt_q;
    logic        tick_q;
    logic        dem_meta_q;
    logic        dem_sync_q;
    logic        dem_tick_q;
    logic [5:0]  cnt_q;
    logic        armed_q;
    logic [4:0]  passed_q;
    logic        fail_q;
    logic        data_q;
    logic        active_q;
    logic        receive_q;
    logic [5:0]  space_q;
    logic [7:0]  low_q;
    logic        block_q;
    logic        access;
    logic        wr;
    logic        start_wr;
    logic        poll_wr;
    logic        edge_w;
    logic        early_w;
    logic        late_w;
    logic        pass_w;
    logic        quiet_w;
    logic [4:0]  needed;

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, ack for one cycle, unmapped reads give zero.
    assign access   = WB_CYC_IN && WB_STB_IN && !ack_q;
    assign wr       = access && WB_WE_IN;
    assign start_wr = wr && WB_ADR_IN == CONTROL_OFS && WB_SEL_IN[0] && WB_DAT_IN[CTRL_START_BIT];
    assign poll_wr  = wr && WB_ADR_IN == CONTROL_OFS && WB_SEL_IN[0] && WB_DAT_IN[CTRL_POLL_BIT];

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= access;
            if (access && !WB_WE_IN) begin
                case (WB_ADR_IN)
                    CONFIG_OFS: rdat_q <= {27'h0, cfg_q};
                    LIMIT_OFS:  rdat_q <= {19'h0, lim_q.lim_max, 3'h0, lim_q.lim_min}; // see [R4]
                    STATUS_OFS: rdat_q <= {11'h0, passed_q, 2'h0, cnt_q, 3'h0, fail_q, 2'h0, state_q};
                    default:    rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            cfg_q <= cfg_t'(CFG_RESET);
            lim_q <= limit_t'(LIMIT_RESET);
        end else if (wr) begin
            if (WB_ADR_IN == CONFIG_OFS && WB_SEL_IN[0]) begin
                cfg_q <= cfg_t'(WB_DAT_IN[4:0]);
            end
            if (WB_ADR_IN == LIMIT_OFS && WB_SEL_IN[0]) begin
                lim_q.lim_min <= WB_DAT_IN[4:0]; // see [R4]
            end
            if (WB_ADR_IN == LIMIT_OFS && WB_SEL_IN[1]) begin
                lim_q.lim_max <= WB_DAT_IN[12:8]; // see [R4]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Extended tick: base clock divider, then 8, 4, 2 or 1 base periods.
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            base_cnt_q <= 16'h0000;
            ext_cnt_q  <= 4'h0;
            tick_q     <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (base_cnt_q >= BASE_LAST) begin
                base_cnt_q <= 16'h0000;
                if (ext_cnt_q >= tick_len(cfg_q.baud_range_select) - 4'h1) begin // see [R19]
                    ext_cnt_q <= 4'h0;
                    tick_q    <= 1'b1;
                end else begin
                    ext_cnt_q <= ext_cnt_q + 4'h1;
                end
            end else begin
                base_cnt_q <= base_cnt_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Demodulator synchroniser and sampling on the tick.
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            dem_meta_q <= 1'b1;
            dem_sync_q <= 1'b1;
            dem_tick_q <= 1'b1;
        end else begin
            dem_meta_q <= DEM_DATA_IN;
            dem_sync_q <= dem_meta_q;
            if (tick_q) begin
                dem_tick_q <= dem_sync_q; // see [R14]
            end
        end
    end

    assign edge_w  = tick_q && dem_sync_q != dem_tick_q; // see [R5]
    assign needed  = checks_needed(cfg_q.bit_code); // see [R1]
    assign early_w = edge_w && armed_q && cnt_q + 6'h01 < {1'b0, lim_q.lim_min}; // see [R3] [R10]
    assign late_w  = tick_q && !edge_w && armed_q && cnt_q + 6'h02 >= {1'b0, lim_q.lim_max}; // see [R3] [R10]
    assign pass_w  = edge_w && armed_q && !early_w;
    assign quiet_w = tick_q && !edge_w && cnt_q == {lim_q.lim_max, 1'b0};

    ////////////////////////////////////////////////////////////////////////////////
    // Mode sequencing.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_SLEEP: begin
                if (start_wr) begin
                    state_d = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                if (tick_q && cnt_q == STARTUP_TICKS - 6'h01) begin // see [R11]
                    state_d = (needed == 5'h00) ? ST_RECEIVE : ST_CHECK; // see [R22]
                end
            end
            ST_CHECK: begin
                if (early_w || late_w) begin
                    state_d = ST_SLEEP; // see [R2]
                end else if (pass_w && passed_q + 5'h01 == needed) begin
                    state_d = ST_RECEIVE; // see [R12] [R20]
                end
            end
            ST_RECEIVE: begin
                if (cfg_q.noise_squelch && quiet_w) begin
                    state_d = ST_CHECK; // see [R17] [R20]
                end
            end
            default: state_d = ST_SLEEP;
        endcase
        if (poll_wr) begin
            state_d = ST_SLEEP; // see [R13]
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            state_q   <= ST_SLEEP;
            active_q  <= 1'b0;
            receive_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            active_q  <= state_d != ST_SLEEP;
            receive_q <= state_d == ST_RECEIVE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interval counter, arming and pass count.
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            cnt_q    <= 6'h00;
            armed_q  <= 1'b0;
            passed_q <= 5'h00;
        end else if (state_d != state_q) begin
            cnt_q    <= 6'h00;
            armed_q  <= 1'b0;
            passed_q <= 5'h00;
        end else begin
            if (state_q != ST_STARTUP && edge_w) begin
                cnt_q <= 6'h00; // see [R21]
            end else if (tick_q && cnt_q != CNT_SAT) begin
                cnt_q <= cnt_q + 6'h01; // see [R9]
            end
            if (state_q == ST_CHECK && edge_w) begin
                armed_q <= 1'b1;
            end
            if (state_q == ST_CHECK && pass_w) begin
                passed_q <= passed_q + 5'h01; // see [R2]
            end
        end
    end

    // Failure flag: a new failure wins over a clearing start command.
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            fail_q <= 1'b0;
        end else if (state_q == ST_CHECK && (early_w || late_w)) begin
            fail_q <= 1'b1;
        end else if (start_wr) begin
            fail_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output conditioning: tick aligned while receiving, spike suppression, low time cap.
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            data_q  <= 1'b1;
            space_q <= 6'h00;
            low_q   <= 8'h00;
            block_q <= 1'b0;
        end else if (state_q != ST_RECEIVE) begin
            data_q  <= 1'b1; // see [R20]
            space_q <= 6'h00;
            low_q   <= 8'h00;
            block_q <= 1'b0;
        end else if (tick_q) begin
            if (!data_q && low_q >= DATA_LOW_MAX - 8'h01) begin
                data_q  <= 1'b1; // see [R16]
                block_q <= 1'b1;
                space_q <= 6'h00;
                low_q   <= 8'h00;
            end else if (block_q) begin
                block_q <= !dem_sync_q;
                if (space_q != CNT_SAT) begin
                    space_q <= space_q + 6'h01;
                end
            end else if (dem_sync_q != data_q && space_q >= DATA_MIN_TICKS - 6'h01) begin // see [R15]
                data_q  <= dem_sync_q; // see [R12] [R14] [R17]
                space_q <= 6'h00;
                low_q   <= 8'h00;
            end else begin
                if (space_q != CNT_SAT) begin
                    space_q <= space_q + 6'h01;
                end
                if (!data_q) begin
                    low_q <= low_q + 8'h01;
                end
            end
        end
    end

    assign WB_DAT_OUT  = rdat_q;
    assign WB_ACK_OUT  = ack_q;
    assign DATA_OUT    = data_q;
    assign ACTIVE_OUT  = active_q;
    assign RECEIVE_OUT = receive_q;

endmodule

/* verification/edge_check_assertions.sv */
// Purpose: Concurrent checks on the ports of the edge timing bit check block.
// Assumes: Tick is at least BASE_DIV system clocks and at most eight times that.
// Notes:   Attached to the design by the bind at the foot of this file.
`timescale 1ns/1ps
module edge_check_assertions
    import edge_check_pkg::*;
#(
    parameter int BASE_DIV = edge_check_pkg::BASE_DIV_CYCLES
) (
    input wire logic        SYS_CLK_IN,
    input wire logic        RST_IN,
    input wire logic        WB_CYC_IN,
    input wire logic        WB_STB_IN,
    input wire logic        WB_WE_IN,
    input wire logic [7:0]  WB_ADR_IN,
    input wire logic [3:0]  WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic        WB_ACK_OUT,
    input wire logic        DATA_OUT,
    input wire logic        ACTIVE_OUT,
    input wire logic        RECEIVE_OUT
);
    localparam int GAP  = 4 * BASE_DIV - 1;
    localparam int LMAX = 128 * 8 * BASE_DIV;
    localparam int STUP = 15 * BASE_DIV;
    logic dq_q;
    int   gap_q;
    int   low_q;
    int   up_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Helper counters of cycles since the last data edge, of low time and of time active.
    always_ff @(posedge SYS_CLK_IN) dq_q <= DATA_OUT;
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) gap_q <= 1000;
        else if (DATA_OUT != dq_q) gap_q <= 0;
        else if (gap_q < 1000) gap_q <= gap_q + 1;
    end
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || DATA_OUT) low_q <= 0;
        else low_q <= low_q + 1;
    end
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || !ACTIVE_OUT) up_q <= 0;
        else if (up_q < 100000) up_q <= up_q + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Properties.
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_take; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT; endsequence
    sequence s_ctl; s_take ##0 (WB_WE_IN && WB_ADR_IN == CONTROL_OFS && WB_SEL_IN[0]); endsequence
    sequence s_start; s_ctl ##0 (WB_DAT_IN[CTRL_START_BIT] && !WB_DAT_IN[CTRL_POLL_BIT]); endsequence
    sequence s_poll; s_ctl ##0 WB_DAT_IN[CTRL_POLL_BIT]; endsequence
    property p_ack_next; s_take |=> WB_ACK_OUT; endproperty
    property p_ack_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
    property p_ack_cause; WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN); endproperty
    property p_start; s_start |-> ##[1:3] ACTIVE_OUT; endproperty
    property p_poll; s_poll |-> ##[1:3] (!ACTIVE_OUT && !RECEIVE_OUT); endproperty
    property p_startup; $rose(RECEIVE_OUT) |-> up_q >= STUP; endproperty
    property p_idle_high; !RECEIVE_OUT && !$past(RECEIVE_OUT) |-> DATA_OUT; endproperty
    property p_rx_active; RECEIVE_OUT |-> ACTIVE_OUT; endproperty
    property p_gap; RECEIVE_OUT && $past(RECEIVE_OUT) && DATA_OUT != dq_q |-> gap_q >= GAP; endproperty
    property p_low; low_q <= LMAX; endproperty

    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_start: assert property (p_start) else $error("start did not wake the block");
    a_poll: assert property (p_poll) else $error("poll did not return to sleep");
    a_startup: assert property (p_startup) else $error("receive inside startup");
    a_idle_high: assert property (p_idle_high) else $error("data low outside receive");
    a_rx_active: assert property (p_rx_active) else $error("receive while asleep");
    a_gap: assert property (p_gap) else $error("data edges too close");
    a_low: assert property (p_low) else $error("data low too long");
endmodule

bind edge_timing_bit_check edge_check_assertions #(.BASE_DIV(BASE_DIV)) chk_u (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
    .WB_ACK_OUT(WB_ACK_OUT), .DATA_OUT(DATA_OUT), .ACTIVE_OUT(ACTIVE_OUT), .RECEIVE_OUT(RECEIVE_OUT));

/* verification/host_model.sv */
// Purpose: Host side of the data line, counting wake-up events.
// Assumes: Data line idles high.
// Notes:   Limits kept in range are written by the bench.
`timescale 1ns/1ps
module host_model (
    input  wire logic clk_in,
    input  wire logic data_in,
    output int        falls_out
);
    logic last_q  = 1'b1;
    int   count_q = 0;

    assign falls_out = count_q;
    // Each falling data edge wakes the host.
    always @(posedge clk_in) begin
        last_q <= data_in;
        if (last_q && !data_in) count_q <= count_q + 1;
    end
endmodule

/* verification/tb.sv */
// Purpose: Self-checking bench of the edge timing bit check block.
// Assumes: BASE_DIV of 2; demodulator edges fall on whole ticks.
// Notes:   Ordinary checks run from a row table, odd cases follow.
`timescale 1ns/1ps
module tb;
    import edge_check_pkg::*;
    localparam int BD = 2;
    typedef struct packed {
        logic [1:0] bits;
        logic [1:0] baud;
        logic [5:0] half;
        logic       pass;
    } row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we  = 1'b0;
    logic        dem = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [3:0]  sl  = 4'hf;
    logic [31:0] wd  = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        ack, dout, act, rcv;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          falls, f0, tk;
    // Bits, baud range, half period in ticks, expected acceptance.
    row_t rows [7] = '{'{2'd1, 2'd0, 6'd18, 1'b1}, '{2'd2, 2'd1, 6'd14, 1'b1}, '{2'd3, 2'd2, 6'd23, 1'b1},
                       '{2'd0, 2'd3, 6'd18, 1'b1}, '{2'd1, 2'd1, 6'd13, 1'b0}, '{2'd1, 2'd3, 6'd25, 1'b0},
                       '{2'd1, 2'd1, 6'd10, 1'b0}};

    initial forever #10 clk = ~clk;
    edge_timing_bit_check #(.BASE_DIV(BD)) dut_u (
        .SYS_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wd), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
        .DEM_DATA_IN(dem), .DATA_OUT(dout), .ACTIVE_OUT(act), .RECEIVE_OUT(rcv));
    host_model host_u (.clk_in(clk), .data_in(dout), .falls_out(falls));

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, wd} <= {2'b11, w, a, sl, d};
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 100);
        rd = rdat;
        {cyc, stb, we} <= 3'b000;
        if (t >= 100) chk(1'b0, 1'b1);
    endtask
    task automatic edges(input int n, input int half);
        repeat (n) begin
            repeat (half * tk) @(posedge clk);
            dem <= ~dem;
        end
    endtask
    task automatic run(input logic [1:0] bits, input logic [1:0] baud, input logic sq, input int half, input int n);
        tk = BD * (8 >> baud);
        wb(1'b1, CONFIG_OFS, {27'h0, sq, bits, baud});
        wb(1'b1, CONTROL_OFS, 32'h1);
        edges(4, 3);
        repeat (6 * tk) @(posedge clk);
        edges(n, half);
        repeat (8) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog and main sequence.
    initial begin
        repeat (60000) @(posedge clk);
        chk(1'b0, 1'b1);
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({ack, dout, act, rcv}, 4'b0100);
        wb(1'b0, CONFIG_OFS, 0); chk(rd, 32'h14);
        wb(1'b0, LIMIT_OFS, 0); chk(rd, 32'h180e);
        wb(1'b1, 8'h10, 32'hff); wb(1'b0, 8'h10, 0); chk(rd, 0);
        wb(1'b0, CONTROL_OFS, 0); chk(rd, 0);
        foreach (rows[i]) begin
            run(rows[i].bits, rows[i].baud, 1'b1, rows[i].half, 6 * rows[i].bits + 2);
            chk(rcv, rows[i].pass);
            wb(1'b0, STATUS_OFS, 0); chk({rd[4], rd[1:0]}, rows[i].pass ? 3'b010 : 3'b100);
            wb(1'b1, CONTROL_OFS, 32'h2);
            repeat (4) @(posedge clk);
            chk(act, 0);
        end
        sl = 4'h2;
        wb(1'b1, CONFIG_OFS, 32'h0);
        sl = 4'hf;
        wb(1'b0, CONFIG_OFS, 0); chk(rd, 32'h15);
        wb(1'b1, LIMIT_OFS, 32'h0c0a);
        wb(1'b0, LIMIT_OFS, 0); chk(rd, 32'h0c0a);
        run(2'd1, 2'd1, 1'b1, 11, 8); chk(rcv, 1);
        repeat (40 * tk) @(posedge clk);
        chk({act, rcv, dout}, 3'b101);
        edges(8, 11);
        repeat (8) @(posedge clk);
        chk(rcv, 1);
        wb(1'b1, LIMIT_OFS, 32'h180e);
        wb(1'b1, CONTROL_OFS, 32'h2);
        f0 = falls;
        run(2'd0, 2'd1, 1'b0, 18, 2); chk(rcv, 1);
        dem <= 1'b0;
        repeat (60 * tk) @(posedge clk);
        chk(dout, 0);
        repeat (100 * tk) @(posedge clk);
        chk({dout, rcv}, 2'b11);
        chk(falls > f0, 1);
        wb(1'b1, CONTROL_OFS, 32'h3);
        repeat (4) @(posedge clk);
        chk({act, rcv}, 0);
        wb(1'b1, CONTROL_OFS, 32'h1);
        repeat (8) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({ack, dout, act, rcv}, 4'b0100);
        wb(1'b0, CONFIG_OFS, 0);
        chk(rd, 32'h14);
        print_verdict();
    end
endmodule
